// ---- core/pin_mux_pkg.sv ----
// constants for the dma and chip select pin mux
// Summary of operation
// - transfer-end enabled: pin drives the channel's completion indication, not the port.
// - stop input enabled with transfer-end off: pin is an input that halts the channel's transfer.
// - end/stop pin is a port bit only when both functions are off.
// - channel 1 request pin feeds the dma controller when selected as source.
// - request pin's port driver stays off unless deliberately enabled.
// - acknowledge enabled: pin drives the dma acknowledge.
// - acknowledge disabled: pin reverts to a port bit.
// - fly-by write strobe enabled: pin drives the write strobe.
// - fly-by read strobe enabled: pin drives the read strobe.
// - each strobe pin is a port bit when its own strobe is off.
// - chip select 0 drives its pin in external bus mode.
// - chip select 0 pin is a port bit in single chip mode.
// - chip selects 1 and 2 drive pins only when individually enabled.
// - chip selects 1 and 2 fall back to port bits when disabled.
package pin_mux_pkg;
	localparam int        SYNC_STAGES = 2;
	localparam logic      ENABLE_RST  = 1'h0;
	localparam logic      PORT_RST    = 1'h0;
	localparam logic      STROBE_IDLE = 1'h1;
	localparam logic      OE_ACTIVE   = 1'h0;
	localparam logic      OE_IDLE     = 1'h1;
	// pin indexes in the pin vectors
	localparam int        PIN_END0 = 0;
	localparam int        PIN_REQ1 = 1;
	localparam int        PIN_ACK1 = 2;
	localparam int        PIN_END1 = 3;
	localparam int        PIN_WR   = 4;
	localparam int        PIN_RD   = 5;
	localparam int        PIN_CS0  = 6;
	localparam int        PIN_CS1  = 7;
	localparam int        PIN_CS2  = 8;
	localparam int        NUM_PINS = 9;
endpackage

// ---- core/pin_sync.sv ----
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pin_sync
	import pin_mux_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	// data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// ---- core/pin_cell.sv ----
// one shared pin: function or port, registered output and enable
`timescale 1ns/100ps
module pin_cell
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// selection
	input  wire logic i_func_sel,
	input  wire logic i_func_out,
	input  wire logic i_func_drive,
	// port bit
	input  wire logic i_port_out,
	input  wire logic i_port_drive,
	// pin
	output logic      o_pin,
	output logic      o_pin_oe_n
);
	logic pin_q;
	logic oe_n_q;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_q  <= PORT_RST;
			oe_n_q <= OE_IDLE;
		end else if (i_func_sel) begin
			pin_q  <= i_func_out;
			oe_n_q <= i_func_drive ? OE_ACTIVE : OE_IDLE;
		end else begin
			pin_q  <= i_port_out;
			oe_n_q <= i_port_drive ? OE_ACTIVE : OE_IDLE;
		end
	end

	assign o_pin      = pin_q;
	assign o_pin_oe_n = oe_n_q;
endmodule

// ---- core/dma_and_chip_select_pin_mux.sv ----
// pin mux for dma handshake, fly-by strobes and chip selects 0..2
`timescale 1ns/100ps
module dma_and_chip_select_pin_mux
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_nrst,
	// function enables
	input  wire logic                i_external_bus_mode,
	input  wire logic                i_ch0_end_out_en,
	input  wire logic                i_ch0_stop_in_en,
	input  wire logic                i_ch1_end_out_en,
	input  wire logic                i_ch1_stop_in_en,
	input  wire logic                i_ch1_request_src_en,
	input  wire logic                i_ch1_ack_out_en,
	input  wire logic                i_flyby_write_en,
	input  wire logic                i_flyby_read_en,
	input  wire logic                i_cs1_out_en,
	input  wire logic                i_cs2_out_en,
	// internal function signals
	input  wire logic                i_dma_ch0_transfer_end,
	input  wire logic                i_dma_ch1_transfer_end,
	input  wire logic                i_dma_ch1_acknowledge,
	input  wire logic                i_flyby_write_strobe_n,
	input  wire logic                i_flyby_read_strobe_n,
	input  wire logic                i_chip_select_zero,
	input  wire logic                i_chip_select_one,
	input  wire logic                i_chip_select_two,
	// port bits
	input  wire logic [NUM_PINS-1:0] i_port_out,
	input  wire logic [NUM_PINS-1:0] i_port_drive,
	output logic      [NUM_PINS-1:0] o_port_in,
	// to dma controller
	output logic                     o_dma_ch0_stop_in,
	output logic                     o_dma_ch1_stop_in,
	output logic                     o_dma_ch1_request_in,
	// pins
	input  wire logic [NUM_PINS-1:0] i_pin,
	output logic      [NUM_PINS-1:0] o_pin,
	output logic      [NUM_PINS-1:0] o_pin_oe_n
);
	logic [NUM_PINS-1:0] pin_sync;
	logic [NUM_PINS-1:0] func_sel;
	logic [NUM_PINS-1:0] func_out;
	logic [NUM_PINS-1:0] func_drive;
	logic [NUM_PINS-1:0] port_in_q;
	logic                ch0_stop_q;
	logic                ch1_stop_q;
	logic                ch1_req_q;

	pin_sync #(
		.WIDTH (NUM_PINS)
	) u_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async (i_pin),
		.o_sync  (pin_sync)
	);

	// function selection per pin; enables are level inputs cleared at reset
	always_comb begin
		func_sel   = '0;
		func_out   = {NUM_PINS{STROBE_IDLE}};
		func_drive = '0;
		// end/stop pin of channel 0
		func_sel[PIN_END0]   = i_ch0_end_out_en | i_ch0_stop_in_en;
		func_out[PIN_END0]   = i_dma_ch0_transfer_end;
		func_drive[PIN_END0] = i_ch0_end_out_en;
		// request pin: never a function driver, port drives only on request
		func_sel[PIN_REQ1]   = 1'h0;
		func_sel[PIN_ACK1]   = i_ch1_ack_out_en;
		func_out[PIN_ACK1]   = i_dma_ch1_acknowledge;
		func_drive[PIN_ACK1] = 1'h1;
		func_sel[PIN_END1]   = i_ch1_end_out_en | i_ch1_stop_in_en;
		func_out[PIN_END1]   = i_dma_ch1_transfer_end;
		func_drive[PIN_END1] = i_ch1_end_out_en;
		func_sel[PIN_WR]     = i_flyby_write_en;
		func_out[PIN_WR]     = i_flyby_write_strobe_n;
		func_drive[PIN_WR]   = 1'h1;
		func_sel[PIN_RD]     = i_flyby_read_en;
		func_out[PIN_RD]     = i_flyby_read_strobe_n;
		func_drive[PIN_RD]   = 1'h1;
		func_sel[PIN_CS0]    = i_external_bus_mode;
		func_out[PIN_CS0]    = i_chip_select_zero;
		func_drive[PIN_CS0]  = 1'h1;
		func_sel[PIN_CS1]    = i_cs1_out_en;
		func_out[PIN_CS1]    = i_chip_select_one;
		func_drive[PIN_CS1]  = 1'h1;
		func_sel[PIN_CS2]    = i_cs2_out_en;
		func_out[PIN_CS2]    = i_chip_select_two;
		func_drive[PIN_CS2]  = 1'h1;
	end

	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		pin_cell u_cell (
			.i_clk        (i_clk),
			.i_nrst       (i_nrst),
			.i_func_sel   (func_sel[g]),
			.i_func_out   (func_out[g]),
			.i_func_drive (func_drive[g]),
			.i_port_out   (i_port_out[g]),
			.i_port_drive (i_port_drive[g]),
			.o_pin        (o_pin[g]),
			.o_pin_oe_n   (o_pin_oe_n[g])
		);
	end

	// stop inputs reach the dma controller only while enabled
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ch0_stop_q <= ENABLE_RST;
			ch1_stop_q <= ENABLE_RST;
		end else begin
			ch0_stop_q <= i_ch0_stop_in_en & pin_sync[PIN_END0];
			ch1_stop_q <= i_ch1_stop_in_en & pin_sync[PIN_END1];
		end
	end

	// request sampled whenever selected as start source
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ch1_req_q <= ENABLE_RST;
		end else begin
			ch1_req_q <= i_ch1_request_src_en & pin_sync[PIN_REQ1];
		end
	end

	// port readback always shows the pin level
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			port_in_q <= '0;
		end else begin
			port_in_q <= pin_sync;
		end
	end

	assign o_dma_ch0_stop_in    = ch0_stop_q;
	assign o_dma_ch1_stop_in    = ch1_stop_q;
	assign o_dma_ch1_request_in = ch1_req_q;
	assign o_port_in            = port_in_q;
endmodule

// ---- verification/ext_devices.sv ----
// far-side memories and io devices sharing the pins
`timescale 1ns/100ps
module ext_devices (
	input  wire logic [8:0] i_lvl,
	input  wire logic [8:0] i_pin,
	input  wire logic [8:0] i_oe_n,
	output logic      [8:0] o_wire
);
	// devices drive every pin the mux has released
	assign o_wire = (i_oe_n & i_lvl) | (~i_oe_n & i_pin);
endmodule

// ---- verification/dma_and_chip_select_pin_mux_assertions.sv ----
// port assertions for the dma and chip select pin mux
`timescale 1ns/100ps
module pin_mux_checker
	import pin_mux_pkg::*;
(
	input wire logic                i_clk, i_nrst, i_external_bus_mode,
	input wire logic                i_ch0_end_out_en, i_ch0_stop_in_en,
	input wire logic                i_ch1_request_src_en, i_chip_select_zero,
	input wire logic                i_dma_ch0_transfer_end, o_dma_ch0_stop_in,
	input wire logic                o_dma_ch1_request_in,
	input wire logic [NUM_PINS-1:0] i_port_drive, i_pin, o_pin, o_pin_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_stop0; i_pin[0] ##2 i_ch0_stop_in_en; endsequence
	sequence s_req1; i_pin[1] ##2 i_ch1_request_src_en; endsequence
	property p_end0; i_ch0_end_out_en |=> !o_pin_oe_n[0]
		&& o_pin[0] == $past(i_dma_ch0_transfer_end); endproperty
	property p_stop0; s_stop0 |=> o_dma_ch0_stop_in; endproperty
	property p_stop_oe;
		!i_ch0_end_out_en && i_ch0_stop_in_en |=> o_pin_oe_n[0]; endproperty
	property p_port0; !i_ch0_end_out_en && !i_ch0_stop_in_en
		|=> o_pin_oe_n[0] == !$past(i_port_drive[0]); endproperty
	property p_req1; s_req1 |=> o_dma_ch1_request_in; endproperty
	property p_req_off;
		!i_ch1_request_src_en |=> !o_dma_ch1_request_in; endproperty
	property p_req_oe; 1 |=> o_pin_oe_n[1] == !$past(i_port_drive[1]);
	endproperty
	property p_cs0; i_external_bus_mode |=> !o_pin_oe_n[6]
		&& o_pin[6] == $past(i_chip_select_zero); endproperty
	a_end0: assert property (p_end0) else $error("end0 pin");
	a_stop0: assert property (p_stop0) else $error("stop0 in");
	a_stop_oe: assert property (p_stop_oe) else $error("stop0 oe");
	a_port0: assert property (p_port0) else $error("port0 oe");
	a_req1: assert property (p_req1) else $error("req1 in");
	a_req_off: assert property (p_req_off) else $error("req1 off");
	a_req_oe: assert property (p_req_oe) else $error("req1 oe");
	a_cs0: assert property (p_cs0) else $error("cs0 pin");
endmodule
bind dma_and_chip_select_pin_mux pin_mux_checker chk (.*);

// ---- verification/dma_and_chip_select_pin_mux_tb_top.sv ----
// random bench for the dma and chip select pin mux
`timescale 1ns/100ps
module dma_and_chip_select_pin_mux_tb_top;
	import pin_mux_pkg::*;
	logic        i_clk = 1'h0;
	logic        i_nrst = 1'h0;
	logic [18:0] c = '0;
	logic [8:0]  pout = '0, pdrv = '0, ext = '0, sel, fv, e_o, e_oe, w;
	logic [8:0]  dsel;
	logic [8:0]  pin_w, o_pin, o_pin_oe_n, o_port_in;
	logic [2:0]  dma_o;
	logic [63:0] r;
	logic [31:0] seed = 32'h685325c5;
	int          error_cnt = 0, comparisons = 0;
	always #2 i_clk = ~i_clk;
	dma_and_chip_select_pin_mux dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_external_bus_mode(c[0]), .i_ch0_end_out_en(c[1]),
		.i_ch0_stop_in_en(c[2]), .i_ch1_end_out_en(c[3]),
		.i_ch1_stop_in_en(c[4]), .i_ch1_request_src_en(c[5]),
		.i_ch1_ack_out_en(c[6]), .i_flyby_write_en(c[7]),
		.i_flyby_read_en(c[8]), .i_cs1_out_en(c[9]), .i_cs2_out_en(c[10]),
		.i_dma_ch0_transfer_end(c[11]), .i_dma_ch1_transfer_end(c[12]),
		.i_dma_ch1_acknowledge(c[13]), .i_flyby_write_strobe_n(c[14]),
		.i_flyby_read_strobe_n(c[15]), .i_chip_select_zero(c[16]),
		.i_chip_select_one(c[17]), .i_chip_select_two(c[18]),
		.i_port_out(pout), .i_port_drive(pdrv), .o_port_in(o_port_in),
		.o_dma_ch0_stop_in(dma_o[0]), .o_dma_ch1_stop_in(dma_o[1]),
		.o_dma_ch1_request_in(dma_o[2]), .i_pin(pin_w), .o_pin(o_pin),
		.o_pin_oe_n(o_pin_oe_n));
	ext_devices partner (.i_lvl(ext), .i_pin(o_pin), .i_oe_n(o_pin_oe_n),
		.o_wire(pin_w));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [8:0] pick(logic [8:0] s, a, b);
		return (s & a) | (~s & b);
	endfunction
	task automatic chk(logic [8:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// function select and value per pin, pin 1 never a function output
	// end/stop pins leave the port when either function is on
	assign sel = {c[10:9], c[0], c[8:7], c[3] | c[4], c[6], 1'h0,
		c[1] | c[2]};
	// pins that the selected function actively drives
	assign dsel = {c[10:9], c[0], c[8:7], c[3], c[6], 1'h0, c[1]};
	assign fv = {c[18:14], c[12], c[13], 1'h0, c[11]};
	assign e_o = pick(sel, fv, pout);
	assign e_oe = ~(dsel | (~sel & pdrv));
	assign w = pick(e_oe, ext, e_o);
	initial begin
		repeat (5000) @(posedge i_clk);
		error_cnt++;
		results();
	end
	initial begin
		repeat (6) @(posedge i_clk);
		chk(o_pin_oe_n, '1);
		chk(o_pin, '0);
		chk({6'h0, dma_o}, '0);
		i_nrst <= 1'h1;
		for (int n = 0; n < 300; n++) begin
			r = {xs(), xs()};
			if (n < 2) r = {64{n[0]}};
			{c, pout, pdrv, ext} <= r[45:0];
			repeat (4) @(posedge i_clk);
			@(negedge i_clk);
			chk(o_pin, e_o);
			chk(o_pin_oe_n, e_oe);
			chk(o_port_in, w);
			chk({6'h0, dma_o}, {6'h0, w[1] & c[5], w[3] & c[4], w[0] & c[2]});
			@(posedge i_clk);
		end
		results();
	end
endmodule
